// >>> rgc_pkg.sv
/*
 Shared constants and types for the rail-six enable gating block.
 Assumes a single 10 MHz clock and register access over 32-bit APB.
*/
package rgc_pkg;

  // Clock and millisecond scale
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;

  // Edge delay table, in milliseconds
  localparam int unsigned DLY_W = 3;
  localparam int unsigned MS_W = 7;
  localparam logic [MS_W-1:0] DLY_MS_0 = 7'h00;
  localparam logic [MS_W-1:0] DLY_MS_1 = 7'h02;
  localparam logic [MS_W-1:0] DLY_MS_2 = 7'h04;
  localparam logic [MS_W-1:0] DLY_MS_3 = 7'h08;
  localparam logic [MS_W-1:0] DLY_MS_4 = 7'h10;
  localparam logic [MS_W-1:0] DLY_MS_5 = 7'h18;
  localparam logic [MS_W-1:0] DLY_MS_6 = 7'h20;
  localparam logic [MS_W-1:0] DLY_MS_7 = 7'h40;
  localparam int unsigned DLY_PCT_TOL = 10;

  // Register indices; byte address is four times the index
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] IDX_GOOD_MASK = 8'h16;
  localparam logic [7:0] IDX_SRC_STEP = 8'h17;
  localparam logic [7:0] IDX_EDGE_DLY = 8'h18;
  localparam logic [7:0] IDX_STATUS = 8'h1f;
  localparam logic [ADDR_W-1:0] ADDR_GOOD_MASK = 12'(IDX_GOOD_MASK * 4);
  localparam logic [ADDR_W-1:0] ADDR_SRC_STEP = 12'(IDX_SRC_STEP * 4);
  localparam logic [ADDR_W-1:0] ADDR_EDGE_DLY = 12'(IDX_EDGE_DLY * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'(IDX_STATUS * 4);

  // Field positions
  localparam int unsigned STEP_BIT = 5;
  localparam int unsigned SRC_LSB = 2;
  localparam int unsigned SRC_W = 3;
  localparam int unsigned MASK2_W = 2;
  localparam int unsigned ON_DLY_LSB = 0;
  localparam int unsigned OFF_DLY_LSB = 3;
  localparam int unsigned GOOD_W = 10;

  // Default image standing in for the one-time-programmable load
  localparam logic [7:0] RST_GOOD_MASK = 8'h00;
  localparam logic [7:0] RST_SRC_STEP = 8'hc0;
  localparam logic [7:0] RST_EDGE_DLY = 8'h00;

  // Enable source codes
  typedef enum logic [SRC_W-1:0] {
    SRC_CTRL_INPUT_1 = 3'h0,
    SRC_CTRL_INPUT_2 = 3'h1,
    SRC_CTRL_INPUT_5 = 3'h2,
    SRC_CTRL_INPUT_4 = 3'h3,
    SRC_CTRL_INPUT_3 = 3'h4,
    SRC_CTL34 = 3'h5,
    SRC_CTRL_INPUT_6 = 3'h6,
    SRC_ALWAYS = 3'h7
  } rgc_src_e;

  // Edge delay states, one-hot
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_RISE = 4'h2,
    ST_ON = 4'h4,
    ST_FALL = 4'h8
  } rgc_dly_state_e;

  // Control pins from the system controller
  typedef struct packed {
    logic ctrl_input_6;
    logic ctrl_input_5;
    logic ctrl_input_4;
    logic ctrl_input_3;
    logic ctrl_input_2;
    logic ctrl_input_1;
  } rgc_ctrl_s;

  // Power-good inputs, ordered as the ten mask bits
  typedef struct packed {
    logic ldo_third;
    logic ldo_second;
    logic load_switch_a1;
    logic buck_rail_5;
    logic buck_rail_4;
    logic buck_rail_3;
    logic buck_rail_2;
    logic buck_rail_1;
    logic switch_b2_ldo_first;
    logic load_switch_b1;
  } rgc_good_s;

  // Delay code to milliseconds
  function automatic logic [MS_W-1:0] rgc_delay_ms(input logic [DLY_W-1:0] code);
    logic [MS_W-1:0] ms;
    ms = DLY_MS_0;
    unique case (code)
      3'h0: ms = DLY_MS_0;
      3'h1: ms = DLY_MS_1;
      3'h2: ms = DLY_MS_2;
      3'h3: ms = DLY_MS_3;
      3'h4: ms = DLY_MS_4;
      3'h5: ms = DLY_MS_5;
      3'h6: ms = DLY_MS_6;
      3'h7: ms = DLY_MS_7;
    endcase
    return ms;
  endfunction : rgc_delay_ms

endpackage : rgc_pkg

// >>> rgc_enable_logic.sv
/*
 Source selection and power-good qualification for rail six.
 Assumes control pins and power-good inputs are synchronous to clk_sys.
*/
`timescale 1ns/1ns
module rgc_enable_logic (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input rgc_pkg::rgc_ctrl_s ctrl,
  input rgc_pkg::rgc_good_s good,
  input wire logic [rgc_pkg::GOOD_W-1:0] good_mask,
  input wire logic [rgc_pkg::SRC_W-1:0] src_sel,
  output logic source_req,
  output logic goods_ok
);
  import rgc_pkg::*;

  logic next_source;

  // Source multiplexer; code seven inserts a constant one
  always_comb begin
    next_source = 1'b0;
    unique case (rgc_src_e'(src_sel))
      SRC_CTRL_INPUT_1: next_source = ctrl.ctrl_input_1;
      SRC_CTRL_INPUT_2: next_source = ctrl.ctrl_input_2;
      SRC_CTRL_INPUT_5: next_source = ctrl.ctrl_input_5;
      SRC_CTRL_INPUT_4: next_source = ctrl.ctrl_input_4;
      SRC_CTRL_INPUT_3: next_source = ctrl.ctrl_input_3;
      SRC_CTL34: next_source = ctrl.ctrl_input_3 & ctrl.ctrl_input_4;
      SRC_CTRL_INPUT_6: next_source = ctrl.ctrl_input_6;
      SRC_ALWAYS: next_source = 1'b1;
    endcase
  end

  // Registered so both terms line up in time
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      source_req <= 1'b0;
      goods_ok <= 1'b0;
    end else begin
      source_req <= next_source;
      goods_ok <= &(good | good_mask);
    end
  end

endmodule : rgc_enable_logic

// >>> rgc_edge_delay.sv
/*
 Delays the rising and falling edges of one level by a coded time.
 Assumes the codes are stable while a delay is running; they are
 sampled when an edge is first seen.
*/
`timescale 1ns/1ns
module rgc_edge_delay #(
  parameter int unsigned CYC_PER_MS = rgc_pkg::CYC_PER_MS,
  parameter int unsigned CNT_W = 20
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic level_in,
  input wire logic [rgc_pkg::DLY_W-1:0] rise_code,
  input wire logic [rgc_pkg::DLY_W-1:0] fall_code,
  output logic level_out,
  output logic busy
);
  import rgc_pkg::*;

  rgc_dly_state_e state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] rise_cyc;
  logic [CNT_W-1:0] fall_cyc;

  // Exact cycle counts; far tighter than the allowed tolerance
  assign rise_cyc = CNT_W'(rgc_delay_ms(rise_code) * CYC_PER_MS);
  assign fall_cyc = CNT_W'(rgc_delay_ms(fall_code) * CYC_PER_MS);

  // A reversed edge during a wait cancels it; no glitch reaches the rail
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ST_OFF;
      cnt <= '0;
      level_out <= 1'b0;
    end else begin
      unique case (state)
        ST_OFF: if (level_in) begin
          if (rise_cyc == '0) begin
            state <= ST_ON;
            level_out <= 1'b1;
          end else begin
            state <= ST_RISE;
            cnt <= rise_cyc - 1'b1;
          end
        end
        ST_RISE: if (!level_in) begin
          state <= ST_OFF;
        end else if (cnt == '0) begin
          state <= ST_ON;
          level_out <= 1'b1;
        end else begin
          cnt <= cnt - 1'b1;
        end
        ST_ON: if (!level_in) begin
          if (fall_cyc == '0) begin
            state <= ST_OFF;
            level_out <= 1'b0;
          end else begin
            state <= ST_FALL;
            cnt <= fall_cyc - 1'b1;
          end
        end
        ST_FALL: if (level_in) begin
          state <= ST_ON;
        end else if (cnt == '0) begin
          state <= ST_OFF;
          level_out <= 1'b0;
        end else begin
          cnt <= cnt - 1'b1;
        end
      endcase
    end
  end

  assign busy = (state == ST_RISE) || (state == ST_FALL);

endmodule : rgc_edge_delay

// >>> rail_enable_gating_ctrl.sv
/*
 Enable gating for the sixth buck rail: source selection, power-good
 qualification, edge delays, step-size select and an APB register slave.
 Assumes one 10 MHz clock, synchronous pins and a standard APB master.
*/
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
module rail_enable_gating_ctrl #(
  parameter int unsigned CYC_PER_MS = rgc_pkg::CYC_PER_MS,
  parameter logic [7:0] OTP_GOOD_MASK = rgc_pkg::RST_GOOD_MASK,
  parameter logic [7:0] OTP_SRC_STEP = rgc_pkg::RST_SRC_STEP,
  parameter logic [7:0] OTP_EDGE_DLY = rgc_pkg::RST_EDGE_DLY
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rgc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input rgc_pkg::rgc_ctrl_s ctrl,
  input rgc_pkg::rgc_good_s good,
  output logic rail6_enable,
  output logic rail6_voltage_step_select
);
  import rgc_pkg::*;

  // Configuration registers
  logic [7:0] rail6_good_mask_primary;
  logic [7:0] rail6_enable_source_step;
  logic [7:0] rail6_enable_edge_delays;

  // Bus decode
  logic setup_phase;
  logic access_done;
  logic wr_en;
  logic hit;
  logic [31:0] next_rdata;

  // Datapath
  logic [GOOD_W-1:0] good_mask;
  logic [SRC_W-1:0] rail6_enable_source_field;
  logic [DLY_W-1:0] rail6_on_delay_field;
  logic [DLY_W-1:0] rail6_off_delay_field;
  logic source_req;
  logic goods_ok;
  logic source_delayed;
  logic delay_busy;
  logic [7:0] status;

  // Field extraction
  assign good_mask = {rail6_good_mask_primary,
                      rail6_enable_source_step[MASK2_W-1:0]};
  assign rail6_enable_source_field =
    rail6_enable_source_step[SRC_LSB +: SRC_W];
  assign rail6_on_delay_field =
    rail6_enable_edge_delays[ON_DLY_LSB +: DLY_W];
  assign rail6_off_delay_field =
    rail6_enable_edge_delays[OFF_DLY_LSB +: DLY_W];

  // APB phases; the slave answers in the first access cycle
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_en = access_done && pwrite && !pslverr && pstrb[0];

  // Address decode
  always_comb begin
    hit = 1'b1;
    next_rdata = '0;
    unique case (paddr)
      ADDR_GOOD_MASK: next_rdata = {24'h000000, rail6_good_mask_primary};
      ADDR_SRC_STEP: next_rdata = {24'h000000, rail6_enable_source_step};
      ADDR_EDGE_DLY: next_rdata = {24'h000000, rail6_enable_edge_delays};
      ADDR_STATUS: next_rdata = {24'h000000, status};
      default: hit = 1'b0;
    endcase
  end

  // Answer registered at setup; held through the access cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (setup_phase) begin
      pready <= 1'b1;
      pslverr <= !hit;
      prdata <= pwrite ? 32'h00000000 : next_rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
  end

  // Mask register; reset loads the programmed default image
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rail6_good_mask_primary <= OTP_GOOD_MASK;
    end else if (wr_en && paddr == ADDR_GOOD_MASK) begin
      rail6_good_mask_primary <= pwdata[7:0];
    end
  end

  // Source and step register; runtime step changes are allowed but
  // discouraged, so the write path is not blocked
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rail6_enable_source_step <= OTP_SRC_STEP;
    end else if (wr_en && paddr == ADDR_SRC_STEP) begin
      rail6_enable_source_step <= pwdata[7:0];
    end
  end

  // Edge delay register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rail6_enable_edge_delays <= OTP_EDGE_DLY;
    end else if (wr_en && paddr == ADDR_EDGE_DLY) begin
      rail6_enable_edge_delays <= pwdata[7:0];
    end
  end

  // Source mux and power-good qualification
  rgc_enable_logic u_enable_logic (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ctrl(ctrl),
    .good(good),
    .good_mask(good_mask),
    .src_sel(rail6_enable_source_field),
    .source_req(source_req),
    .goods_ok(goods_ok)
  );

  // Edge delays act on the selected source only
  rgc_edge_delay #(
    .CYC_PER_MS(CYC_PER_MS),
    .CNT_W(20)
  ) u_edge_delay (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .level_in(source_req),
    .rise_code(rail6_on_delay_field),
    .fall_code(rail6_off_delay_field),
    .level_out(source_delayed),
    .busy(delay_busy)
  );

  // Rail enable; a lost power-good drops the rail two cycles later, without waiting for the off delay
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rail6_enable <= 1'b0;
    end else begin
      rail6_enable <= source_delayed && goods_ok;
    end
  end

  // Step select to the regulator reference
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rail6_voltage_step_select <= 1'b0;
    end else begin
      rail6_voltage_step_select <= rail6_enable_source_step[STEP_BIT];
    end
  end

  // Read-only status word
  assign status = {4'h0, delay_busy, goods_ok, source_req, rail6_enable};

endmodule : rail_enable_gating_ctrl

// >>> rgc_checker.sv
/*
 Assertion checker for the rail-six enable gating block.
 Assumes it sees only the top ports; bound at the foot of this file.
*/
`timescale 1ns/1ns
module rgc_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rgc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input rgc_pkg::rgc_ctrl_s ctrl,
  input rgc_pkg::rgc_good_s good,
  input wire logic rail6_enable,
  input wire logic rail6_voltage_step_select
);
  import rgc_pkg::*;
  logic [GOOD_W-1:0] sh_mask;
  logic wr_done;
  logic ok_sh;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Shadow of the mask bits, so gating can be judged at the pins
  assign wr_done = psel && penable && pready && pwrite && pstrb[0];
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sh_mask <= {RST_GOOD_MASK, RST_SRC_STEP[1:0]};
    end else if (wr_done && paddr == ADDR_GOOD_MASK) begin
      sh_mask[9:2] <= pwdata[7:0];
    end else if (wr_done && paddr == ADDR_SRC_STEP) begin
      sh_mask[1:0] <= pwdata[1:0];
    end
  end
  assign ok_sh = &(good | sh_mask);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_step_wr;
    wr_done && paddr == ADDR_SRC_STEP;
  endsequence
  property p_ready_after_setup;
    s_setup |=> pready;
  endproperty
  property p_ready_once;
    pready |=> !pready;
  endproperty
  property p_err_data;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  property p_idle_data;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_step;
    s_step_wr |=> ##1 rail6_voltage_step_select == $past(pwdata[5], 2);
  endproperty
  property p_good_loss;
    !ok_sh |-> ##2 !rail6_enable;
  endproperty
  property p_rise_goods;
    $rose(rail6_enable) |-> $past(ok_sh, 2);
  endproperty
  property p_rst_off;
    disable iff (1'b0) sys_rst |=> !rail6_enable && !pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("ready missing after setup");
  a_ready_once: assert property (p_ready_once)
    else $error("ready longer than one cycle");
  a_err_data: assert property (p_err_data)
    else $error("error without ready or with data");
  a_idle_data: assert property (p_idle_data)
    else $error("read data outside access");
  a_step: assert property (p_step)
    else $error("step select not following write");
  a_good_loss: assert property (p_good_loss)
    else $error("enable kept without power good");
  a_rise_goods: assert property (p_rise_goods)
    else $error("enable rose without power good");
  a_rst_off: assert property (p_rst_off)
    else $error("outputs active after reset");
endmodule : rgc_checker

bind rail_enable_gating_ctrl rgc_checker i_chk (.clk_sys, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ctrl, .good,
  .rail6_enable, .rail6_voltage_step_select);

// >>> rgc_ctrl_model.sv
/*
 Behavioural system controller driving the six control pins.
 Assumes the bench gives wanted levels and a lag in clk_sys cycles.
*/
`timescale 1ns/1ns
module rgc_ctrl_model (
  input wire logic clk_sys,
  input wire logic [5:0] pins,
  input wire logic [3:0] lag,
  output rgc_pkg::rgc_ctrl_s ctrl = '0
);
  import rgc_pkg::*;
  logic [3:0] cnt = 4'h0;
  // Pins settle after the lag, as a slow controller would
  always @(posedge clk_sys) begin
    if (6'(ctrl) === pins) begin
      cnt <= 4'h0;
    end else if (cnt < lag) begin
      cnt <= cnt + 4'h1;
    end else begin
      ctrl <= rgc_ctrl_s'(pins);
      cnt <= 4'h0;
    end
  end
endmodule : rgc_ctrl_model

// >>> tb_rail_enable_gating_ctrl.sv
/*
 Testbench for the rail-six enable gating block, APB master and scenarios.
 Assumes the checker binds itself and the pins come from rgc_ctrl_model.
*/
`timescale 1ns/1ns
module tb_rail_enable_gating_ctrl;
  import rgc_pkg::*;
  localparam int unsigned CPM = 10;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] pins = '0;
  logic [3:0] lag = '0;
  rgc_ctrl_s ctrl;
  rgc_good_s good = '1;
  logic rail6_enable;
  logic rail6_voltage_step_select;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] rd;
  logic err;
  logic [5:0] sel [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0c, 6'h20, 6'h00};
  int ms [8] = '{0, 2, 4, 8, 16, 24, 32, 64};

  // Short millisecond keeps the 64 ms case cheap
  rail_enable_gating_ctrl #(.CYC_PER_MS(CPM)) i_dut (.clk_sys, .sys_rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ctrl, .good,
    .rail6_enable, .rail6_voltage_step_select);
  rgc_ctrl_model i_ctrl (.clk_sys, .pins, .lag, .ctrl);

  // 10 MHz clock
  always #50 clk_sys = ~clk_sys;

  task automatic finish_test();
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; waits for ready, bounded
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      finish_test();
    end
  endtask : apb

  task automatic wait_en(input logic exp, input int lim, output int n);
    n = 0;
    while (rail6_enable !== exp && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    check(rail6_enable, exp);
    if (rail6_enable !== exp) finish_test();
  endtask : wait_en

  task automatic set_mask(input logic [9:0] m);
    apb(1'b1, ADDR_GOOD_MASK, {24'h0, m[9:2]});
    apb(1'b1, ADDR_SRC_STEP, {24'h0, 6'h37, m[1:0]});
  endtask : set_mask

  task automatic t_regs();
    apb(1'b0, ADDR_GOOD_MASK, 32'h0);
    check(rd, {24'h0, RST_GOOD_MASK});
    apb(1'b0, ADDR_SRC_STEP, 32'h0);
    check(rd, {24'h0, RST_SRC_STEP});
    // Step size comes from the loaded default image, not a runtime write
    check(rail6_voltage_step_select, RST_SRC_STEP[STEP_BIT]);
    apb(1'b1, 12'h000, 32'h5a);
    check(err, 1'b1);
    apb(1'b1, ADDR_EDGE_DLY, 32'h3f);
    apb(1'b0, ADDR_EDGE_DLY, 32'h0);
    check(rd, 32'h3f);
    apb(1'b1, ADDR_EDGE_DLY, 32'h0);
  endtask : t_regs

  task automatic t_src();
    int n;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, ADDR_SRC_STEP, {24'h0, 3'b110, 3'(c), 2'b00});
      pins <= (c == 5) ? 6'h3b : ~sel[c];
      repeat (8) @(posedge clk_sys);
      check(rail6_enable, c == 7);
      pins <= sel[c];
      wait_en(1'b1, 10, n);
      // Let an edge pass so the pins are never driven twice in one step
      @(posedge clk_sys);
      pins <= 6'h00;
      wait_en(c == 7, 10, n);
    end
  endtask : t_src

  task automatic t_mask();
    int n;
    for (int i = 0; i < GOOD_W; i++) begin
      good <= rgc_good_s'(~(10'h1 << i));
      repeat (5) @(posedge clk_sys);
      check(rail6_enable, 1'b0);
      set_mask(10'h1 << i);
      wait_en(1'b1, 10, n);
      set_mask(10'h0);
      wait_en(1'b0, 10, n);
    end
    good <= '1;
  endtask : t_mask

  // Slow controller lag grows with the code; tolerance is ten percent
  task automatic t_dly();
    int n;
    int tgt;
    apb(1'b1, ADDR_SRC_STEP, 32'hc0);
    // Rail must be off before the first rise is timed
    wait_en(1'b0, 10, n);
    for (int c = 0; c < 8; c++) begin
      tgt = ms[c] * CPM;
      apb(1'b1, ADDR_EDGE_DLY, {26'h0, 3'(c), 3'(c)});
      lag <= 4'(c);
      pins <= 6'h01;
      wait_en(1'b1, 800, n);
      check(n - c >= tgt - tgt / 10 && n - c <= tgt + tgt / 10 + 5, 1'b1);
      pins <= 6'h00;
      wait_en(1'b0, 800, n);
      check(n - c >= tgt - tgt / 10 && n - c <= tgt + tgt / 10 + 5, 1'b1);
    end
  endtask : t_dly

  task automatic t_step();
    apb(1'b1, ADDR_SRC_STEP, 32'he0);
    repeat (2) @(posedge clk_sys);
    check(rail6_voltage_step_select, 1'b1);
    pstrb <= 4'h0;
    apb(1'b1, ADDR_SRC_STEP, 32'hc0);
    pstrb <= 4'hf;
    apb(1'b0, ADDR_SRC_STEP, 32'h0);
    check(rd, 32'he0);
    // Status is read-only: a write is ignored without an error
    apb(1'b1, ADDR_STATUS, 32'hff);
    check(err, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h4);
  endtask : t_step

  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs();
    t_src();
    t_mask();
    t_dly();
    t_step();
    finish_test();
  end
endmodule : tb_rail_enable_gating_ctrl
